/* common/tac_pkg.sv */
package tac_pkg;

    typedef logic signed [15:0] tac_val_t;

    typedef enum logic [3:0] {
        TAC_K_OFF          = 4'h0,
        TAC_K_BAND_OUT     = 4'h1,
        TAC_K_UPPER        = 4'h2,
        TAC_K_LOWER        = 4'h3,
        TAC_K_BAND_IN      = 4'h4,
        TAC_K_BAND_OUT_SB  = 4'h5,
        TAC_K_UPPER_SB     = 4'h6,
        TAC_K_LOWER_SB     = 4'h7,
        TAC_K_ABS_UPPER    = 4'h8,
        TAC_K_ABS_LOWER    = 4'h9,
        TAC_K_ABS_UPPER_SB = 4'hA,
        TAC_K_ABS_LOWER_SB = 4'hB,
        TAC_K_LOOP_BREAK   = 4'hC
    } tac_kind_t;

    typedef struct packed {
        tac_val_t thresh;
        tac_val_t high;
        tac_val_t low;
        logic [13:0] hys;
    } tac_ch_cfg_t;

    typedef struct packed {
        logic range;
        logic trip;
    } tac_eval_t;

    // Register byte offsets.
    localparam logic [7:0] TAC_OFS_CTRL = 8'h00;
    localparam logic [7:0] TAC_OFS_KIND = 8'h04;
    localparam logic [7:0] TAC_OFS_SETPOINT = 8'h08;
    localparam logic [7:0] TAC_OFS_COMP = 8'h0C;
    localparam logic [7:0] TAC_OFS_THRESH1 = 8'h10;
    localparam logic [7:0] TAC_OFS_THRESH2 = 8'h14;
    localparam logic [7:0] TAC_OFS_HIGH1 = 8'h18;
    localparam logic [7:0] TAC_OFS_LOW1 = 8'h1C;
    localparam logic [7:0] TAC_OFS_HIGH2 = 8'h20;
    localparam logic [7:0] TAC_OFS_LOW2 = 8'h24;
    localparam logic [7:0] TAC_OFS_DEADBAND1 = 8'h28;
    localparam logic [7:0] TAC_OFS_DEADBAND2 = 8'h2C;
    localparam logic [7:0] TAC_OFS_ALARM_WORD = 8'h30;
    localparam logic [7:0] TAC_OFS_IRQ_STAT = 8'h34;
    localparam logic [7:0] TAC_OFS_IRQ_MASK = 8'h38;
    localparam logic [7:0] TAC_OFS_EVENT = 8'h3C;
    localparam logic [7:0] TAC_OFS_MEASURED = 8'h40;

    // Field positions.
    localparam int TAC_RESTART_BIT = 0;
    localparam int TAC_KIND1_LSB = 0;
    localparam int TAC_KIND2_LSB = 4;
    localparam int TAC_ARMED_LSB = 4;
    localparam int TAC_ACT_KIND_LSB = 8;

    // Reset values and limits.
    localparam tac_val_t TAC_VAL_RST = 16'h0000;
    localparam logic [3:0] TAC_KIND_RST = 4'h0;
    localparam logic [13:0] TAC_HYS_MIN = 14'h0001;
    localparam logic [13:0] TAC_HYS_MAX = 14'h270F;
    localparam logic [13:0] TAC_HYS_RST = 14'h0002;
    localparam logic [31:0] TAC_EVENT_CODE = 32'h652E_0000;

    // Standby kinds fold onto their plain counterpart.
    function automatic logic [3:0] tac_base_kind(input logic [3:0] k, input logic second);
        case (k)
            TAC_K_BAND_OUT_SB: tac_base_kind = TAC_K_BAND_OUT;
            TAC_K_UPPER_SB: tac_base_kind = TAC_K_UPPER;
            TAC_K_LOWER_SB: tac_base_kind = TAC_K_LOWER;
            TAC_K_ABS_UPPER_SB: tac_base_kind = TAC_K_ABS_UPPER;
            TAC_K_ABS_LOWER_SB: tac_base_kind = TAC_K_ABS_LOWER;
            TAC_K_LOOP_BREAK: tac_base_kind = second ? TAC_K_OFF : TAC_K_LOOP_BREAK;
            default: tac_base_kind = (k > TAC_K_LOOP_BREAK) ? TAC_K_OFF : k;
        endcase
    endfunction

    function automatic logic tac_has_standby(input logic [3:0] k);
        tac_has_standby = (k == TAC_K_BAND_OUT_SB) || (k == TAC_K_UPPER_SB) ||
            (k == TAC_K_LOWER_SB) || (k == TAC_K_ABS_UPPER_SB) || (k == TAC_K_ABS_LOWER_SB);
    endfunction

endpackage

/* logic/tac_alarm.sv */
`timescale 1ns/1ps
module tac_alarm import tac_pkg::*; (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Measured value from the sampling logic on hclk
    input wire logic signed [15:0] measured_value,
    input wire logic sample_stb,
    // Alarm outputs
    output logic [1:0] alarm_detect,
    output logic alarm_event,
    output logic [31:0] event_code,
    output logic loop_break_alarm_sel,
    output logic irq
);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic wr_en;
    logic [31:0] wd;
    logic addr_ok;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = wr_pend_q;
    assign wd = hwdata;
    assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite && addr_ok;
            rd_pend_q <= hsel && htrans[1] && !hwrite && addr_ok;
            addr_q <= haddr[7:0];
        end
    end

    // ------------------------------------------------------------
    // Settings written by the host
    // ------------------------------------------------------------
    logic [3:0] kind_pend_q [2];
    logic [3:0] kind_act_q [2];
    tac_ch_cfg_t cfg_q [2];
    tac_val_t setpoint_q;
    logic [31:0] comp_q;
    logic restart;
    logic [1:0] rearm;
    logic [13:0] hys_in;

    function automatic logic [13:0] clamp_hys(input logic [31:0] v);
        if (v[31:14] != 18'h00000 || v[13:0] > TAC_HYS_MAX) begin
            clamp_hys = TAC_HYS_MAX;
        end else if (v[13:0] < TAC_HYS_MIN) begin
            clamp_hys = TAC_HYS_MIN;
        end else begin
            clamp_hys = v[13:0];
        end
    endfunction

    assign hys_in = clamp_hys(wd);
    assign restart = wr_en && (addr_q == TAC_OFS_CTRL) && wd[TAC_RESTART_BIT];

    // Any change of a value that moves the trip point restarts the standby wait.
    always_comb begin
        rearm[0] = restart;
        rearm[1] = restart;
        if (wr_en) begin
            if (addr_q == TAC_OFS_SETPOINT || addr_q == TAC_OFS_COMP) begin
                rearm = 2'h3;
            end
            if (addr_q == TAC_OFS_THRESH1 || addr_q == TAC_OFS_HIGH1 ||
                addr_q == TAC_OFS_LOW1) begin
                rearm[0] = 1'b1;
            end
            if (addr_q == TAC_OFS_THRESH2 || addr_q == TAC_OFS_HIGH2 ||
                addr_q == TAC_OFS_LOW2) begin
                rearm[1] = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            setpoint_q <= TAC_VAL_RST;
            comp_q <= 32'h0000_0000;
            for (int i = 0; i < 2; i++) begin
                cfg_q[i] <= '{TAC_VAL_RST, TAC_VAL_RST, TAC_VAL_RST, TAC_HYS_RST};
                kind_pend_q[i] <= TAC_KIND_RST;
            end
        end else if (wr_en) begin
            case (addr_q)
                TAC_OFS_KIND: begin
                    kind_pend_q[0] <= wd[TAC_KIND1_LSB +: 4];
                    kind_pend_q[1] <= wd[TAC_KIND2_LSB +: 4];
                end
                TAC_OFS_SETPOINT: setpoint_q <= wd[15:0];
                TAC_OFS_COMP: comp_q <= wd;
                TAC_OFS_THRESH1: cfg_q[0].thresh <= wd[15:0];
                TAC_OFS_THRESH2: cfg_q[1].thresh <= wd[15:0];
                TAC_OFS_HIGH1: cfg_q[0].high <= wd[15:0];
                TAC_OFS_LOW1: cfg_q[0].low <= wd[15:0];
                TAC_OFS_HIGH2: cfg_q[1].high <= wd[15:0];
                TAC_OFS_LOW2: cfg_q[1].low <= wd[15:0];
                TAC_OFS_DEADBAND1: cfg_q[0].hys <= hys_in;
                TAC_OFS_DEADBAND2: cfg_q[1].hys <= hys_in;
                default: ;
            endcase
        end
    end

    // A running comparison must not see its kind change under it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kind_act_q[0] <= TAC_KIND_RST;
            kind_act_q[1] <= TAC_KIND_RST;
        end else if (restart) begin
            kind_act_q[0] <= (kind_pend_q[0] > TAC_K_LOOP_BREAK) ? TAC_KIND_RST : kind_pend_q[0];
            kind_act_q[1] <= (kind_pend_q[1] > TAC_K_LOOP_BREAK) ? TAC_KIND_RST : kind_pend_q[1];
        end
    end

    assign loop_break_alarm_sel = (kind_act_q[0] == TAC_K_LOOP_BREAK);

    // ------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------
    function automatic tac_eval_t tac_eval(input logic [3:0] k, input tac_val_t pv,
                                           input tac_val_t sp, input tac_ch_cfg_t c,
                                           input logic cur);
        logic signed [17:0] p;
        logic signed [17:0] h;
        logic signed [17:0] up;
        logic signed [17:0] lo;
        logic signed [17:0] x;
        tac_eval_t r;
        p = 18'(pv);
        h = 18'({4'h0, c.hys});
        x = 18'(c.thresh);
        up = 18'(sp) + 18'(c.high);
        lo = 18'(sp) - 18'(c.low);
        r = '0;
        case (k)
            TAC_K_BAND_OUT: begin
                r.range = (p > up) || (p < lo);
                r.trip = cur ? !((p <= up - h) && (p >= lo + h)) : r.range;
            end
            TAC_K_BAND_IN: begin
                r.range = (p >= lo) && (p <= up);
                r.trip = cur ? ((p > lo - h) && (p < up + h)) : r.range;
            end
            TAC_K_UPPER: begin
                r.range = p > 18'(sp) + x;
                r.trip = cur ? (p > 18'(sp) + x - h) : r.range;
            end
            TAC_K_LOWER: begin
                r.range = p < 18'(sp) - x;
                r.trip = cur ? (p < 18'(sp) - x + h) : r.range;
            end
            TAC_K_ABS_UPPER: begin
                r.range = p > x;
                r.trip = cur ? (p > x - h) : r.range;
            end
            TAC_K_ABS_LOWER: begin
                r.range = p < x;
                r.trip = cur ? (p < x + h) : r.range;
            end
            default: r = '0;
        endcase
        return r;
    endfunction

    logic [1:0] det_q;
    logic [1:0] armed_q;
    logic [1:0] det_d;
    logic [1:0] sb;
    tac_eval_t res [2];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            res[i] = tac_eval(tac_base_kind(kind_act_q[i], i == 1), measured_value,
                              setpoint_q, cfg_q[i], det_q[i]);
            sb[i] = tac_has_standby(kind_act_q[i]);
            det_d[i] = res[i].trip && !(sb[i] && armed_q[i]);
        end
    end

    // Armed from reset, so a value already in range at power-up stays quiet.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_q <= 2'h3;
            det_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (rearm[i]) begin
                    armed_q[i] <= 1'b1;
                end else if (sample_stb && !res[i].range) begin
                    armed_q[i] <= 1'b0;
                end
                if (restart) begin
                    det_q[i] <= 1'b0;
                end else if (sample_stb) begin
                    det_q[i] <= det_d[i];
                end
            end
        end
    end

    assign alarm_detect = det_q;

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    logic [1:0] rise;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [1:0] w1c;

    assign rise = det_d & ~det_q & {2{sample_stb && !restart}};
    assign w1c = (wr_en && addr_q == TAC_OFS_IRQ_STAT) ? wd[1:0] : 2'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_event <= 1'b0;
            event_code <= 32'h0000_0000;
        end else begin
            alarm_event <= |rise;
            if (|rise) begin
                event_code <= TAC_EVENT_CODE;
            end
        end
    end

    // Set wins over a clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~w1c) | rise;
            if (wr_en && addr_q == TAC_OFS_IRQ_MASK) begin
                irq_mask_q <= wd[1:0];
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_pend_q) begin
            case (addr_q)
                TAC_OFS_KIND: hrdata = {24'h0, kind_pend_q[1], kind_pend_q[0]};
                TAC_OFS_SETPOINT: hrdata = {16'h0, setpoint_q};
                TAC_OFS_COMP: hrdata = comp_q;
                TAC_OFS_THRESH1: hrdata = {16'h0, cfg_q[0].thresh};
                TAC_OFS_THRESH2: hrdata = {16'h0, cfg_q[1].thresh};
                TAC_OFS_HIGH1: hrdata = {16'h0, cfg_q[0].high};
                TAC_OFS_LOW1: hrdata = {16'h0, cfg_q[0].low};
                TAC_OFS_HIGH2: hrdata = {16'h0, cfg_q[1].high};
                TAC_OFS_LOW2: hrdata = {16'h0, cfg_q[1].low};
                TAC_OFS_DEADBAND1: hrdata = {18'h0, cfg_q[0].hys};
                TAC_OFS_DEADBAND2: hrdata = {18'h0, cfg_q[1].hys};
                TAC_OFS_ALARM_WORD: hrdata = {16'h0, kind_act_q[1], kind_act_q[0],
                                              2'h0, armed_q, 2'h0, det_q};
                TAC_OFS_IRQ_STAT: hrdata = {30'h0, irq_stat_q};
                TAC_OFS_IRQ_MASK: hrdata = {30'h0, irq_mask_q};
                TAC_OFS_EVENT: hrdata = TAC_EVENT_CODE;
                TAC_OFS_MEASURED: hrdata = {16'h0, measured_value};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rise;
        sample_stb && !restart && det_d[0] && !det_q[0];
    endsequence

    // Channel one cannot rise twice in a row, so a second pulse can only be channel two's.
    sequence s_pulse;
        (alarm_event && irq_stat_q[0]) ##1 (!alarm_event || $past(rise[1]));
    endsequence

    a_off_kind_quiet: assert property (kind_act_q[0] == TAC_K_OFF |-> !det_q[0])
        else $error("channel one alarm set with kind off");
    a_ch2_loopbrk_off: assert property (kind_act_q[1] == TAC_K_LOOP_BREAK |-> !det_q[1])
        else $error("channel two alarm set with kind 12");
    a_standby_mute: assert property (sb[0] && armed_q[0] && sample_stb |=> !det_q[0])
        else $error("alarm raised while standby armed");
    a_rearm_setpoint: assert property (wr_en && addr_q == TAC_OFS_SETPOINT |=> armed_q == 2'h3)
        else $error("setpoint write did not re-arm standby");
    a_disarm_outside: assert property (sample_stb && !res[1].range && !rearm[1]
                                       |=> !armed_q[1])
        else $error("standby not cleared outside range");
    a_event_edge: assert property (s_rise |=> s_pulse)
        else $error("event pulse wrong on alarm rise");
    a_event_code: assert property (alarm_event |-> event_code == TAC_EVENT_CODE)
        else $error("event code wrong");
    a_abs_upper_trip: assert property (kind_act_q[0] == TAC_K_ABS_UPPER && sample_stb && !restart
                                       && measured_value > cfg_q[0].thresh |=> det_q[0])
        else $error("absolute upper alarm missed");
    a_hys_hold: assert property (kind_act_q[0] == TAC_K_ABS_UPPER && det_q[0] && sample_stb
                                 && !restart && $signed(18'(measured_value)) >
                                 $signed(18'(cfg_q[0].thresh)) -
                                 $signed(18'({4'h0, cfg_q[0].hys}))
                                 |=> det_q[0])
        else $error("alarm dropped inside deadband");
    a_irq_level: assert property (irq_stat_q[1] && irq_mask_q[1] |-> irq)
        else $error("interrupt not raised");

endmodule // tac_alarm

/* tb/tac_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host controller model
// ----------------------------------------
module tac_host_model (
    // Clock
    input wire logic hclk,
    // Bus master
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Sample source
    output logic signed [15:0] measured_value,
    output logic sample_stb
);
    bit tmo;
    initial begin
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        measured_value = 16'h0000;
        sample_stb = 1'b0;
        tmo = 1'b0;
    end
    // A slave that never answers must not hang the run.
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 50) tmo = 1'b1;
    endtask
    // Settings travel as whole words, one per register.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic sample(input logic signed [15:0] v);
        measured_value <= v;
        sample_stb <= 1'b1;
        @(posedge hclk);
        sample_stb <= 1'b0;
    endtask
endmodule // tac_host_model

/* tb/temperature_alarm_comparator_bench.sv */
`timescale 1ns/1ps
module temperature_alarm_comparator_bench import tac_pkg::*; ;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, sample_stb, alarm_event, loop_break_alarm_sel, irq;
    logic [31:0] haddr, hwdata, hrdata, event_code, q;
    logic [1:0] htrans, alarm_detect;
    logic [2:0] hsize;
    logic signed [15:0] measured_value;
    int miscompares, n_checks, sp, th, hi, lo, hy, pv;
    int seed = 32'hd88e8944;
    bit p, d, arm;
    logic [3:0] kt [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'h5, 4'h6, 4'hA, 4'hB};
    logic [3:0] kb [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'h1, 4'h2, 4'h8, 4'h9};

    always #4 hclk = ~hclk;

    tac_host_model host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .measured_value(measured_value), .sample_stb(sample_stb));

    tac_alarm uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .measured_value(measured_value), .sample_stb(sample_stb),
        .alarm_detect(alarm_detect), .alarm_event(alarm_event), .event_code(event_code),
        .loop_break_alarm_sel(loop_break_alarm_sel), .irq(irq));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (host.tmo) miscompares++;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] r;
        host.xfer(a, 1'b1, v, r);
        if (host.tmo) complete_run();
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(a, 1'b0, 32'h0, q);
        if (host.tmo) complete_run();
    endtask
    task automatic restart();
        wr(TAC_OFS_CTRL, 32'h1);
    endtask
    // The event lands with the detection; a pulse one cycle later would also count, so two cycles are watched.
    task automatic smp(input logic signed [15:0] v, input logic [1:0] det, input bit ev);
        logic e;
        host.sample(v);
        #1;
        check("alarm_detect", {30'h0, alarm_detect}, {30'h0, det});
        e = alarm_event;
        @(posedge hclk);
        #1;
        e = e | alarm_event;
        check("alarm_event", {31'h0, e}, {31'h0, ev});
        @(posedge hclk);
    endtask
    function automatic bit above(input int v, l, h, input bit was);
        above = v > l || (was && v > l - h);
    endfunction
    function automatic bit below(input int v, l, h, input bit was);
        below = v < l || (was && v < l + h);
    endfunction
    function automatic bit ref_det(input logic [3:0] k, input int v, s, t, up, dn, h,
                                   input bit was);
        case (k)
            4'h1: ref_det = above(v, s + up, h, was) || below(v, s - dn, h, was);
            4'h2: ref_det = above(v, s + t, h, was);
            4'h3: ref_det = below(v, s - t, h, was);
            4'h4: ref_det = (v >= s - dn && v <= s + up) ||
                (was && v > s - dn - h && v < s + up + h);
            4'h8: ref_det = above(v, t, h, was);
            4'h9: ref_det = below(v, t, h, was);
            default: ref_det = 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        #500000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        check("reset outputs", {25'h0, alarm_event, loop_break_alarm_sel, hreadyout,
            alarm_detect, irq, hresp}, 32'h0000_0010);
        check("event_code reset", event_code, 32'h0);
        @(posedge hclk);
        rd(TAC_OFS_KIND);
        check("kind reset", q, 32'h0);
        rd(TAC_OFS_DEADBAND1);
        check("deadband reset", q, 32'h2);
        rd(8'h44);
        check("unmapped", q, 32'h0);
        rd(TAC_OFS_EVENT);
        check("event reg", q, 32'h652E0000);
        wr(TAC_OFS_DEADBAND1, 32'h0);
        rd(TAC_OFS_DEADBAND1);
        check("deadband low", q, 32'h1);
        wr(TAC_OFS_DEADBAND1, 32'h2710);
        rd(TAC_OFS_DEADBAND1);
        check("deadband high", q, 32'h270F);
        // Kind is pending until restart; then hysteresis corner at 100 with band 2.
        wr(TAC_OFS_DEADBAND1, 32'h2);
        wr(TAC_OFS_THRESH1, 32'h64);
        wr(TAC_OFS_IRQ_MASK, 32'h1);
        wr(TAC_OFS_KIND, 32'h8);
        rd(TAC_OFS_ALARM_WORD);
        check("kind pending", {28'h0, q[11:8]}, 32'h0);
        restart();
        rd(TAC_OFS_ALARM_WORD);
        check("kind active", {28'h0, q[11:8]}, 32'h8);
        smp(16'sd100, 2'b00, 1'b0);
        smp(16'sd101, 2'b01, 1'b1);
        check("event_code", event_code, 32'h652E0000);
        check("irq on", {31'h0, irq}, 32'h1);
        smp(16'sd99, 2'b01, 1'b0);
        smp(16'sd98, 2'b00, 1'b0);
        wr(TAC_OFS_IRQ_STAT, 32'h1);
        #1;
        check("irq cleared", {31'h0, irq}, 32'h0);
        // Standby lower alarm on channel one, loop break code on channel two.
        wr(TAC_OFS_SETPOINT, 32'h0);
        wr(TAC_OFS_THRESH1, 32'hA);
        wr(TAC_OFS_KIND, 32'hC7);
        restart();
        #1;
        check("loop break sel ch2", {31'h0, loop_break_alarm_sel}, 32'h0);
        @(posedge hclk);
        smp(-16'sd20, 2'b00, 1'b0);
        smp(16'sd0, 2'b00, 1'b0);
        smp(-16'sd20, 2'b01, 1'b1);
        wr(TAC_OFS_IRQ_STAT, 32'h1);
        wr(TAC_OFS_IRQ_MASK, 32'h0);
        wr(TAC_OFS_SETPOINT, 32'h0);
        smp(-16'sd20, 2'b00, 1'b0);
        smp(16'sd0, 2'b00, 1'b0);
        smp(-16'sd20, 2'b01, 1'b1);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd(TAC_OFS_IRQ_STAT);
        check("irq stat", q, 32'h1);
        wr(TAC_OFS_IRQ_MASK, 32'h1);
        #1;
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr(TAC_OFS_KIND, 32'hC);
        restart();
        #1;
        check("loop break sel ch1", {31'h0, loop_break_alarm_sel}, 32'h1);
        @(posedge hclk);
        // Random sweep of the plain kinds and four of the five standby kinds (not 7) against the reference comparison.
        for (int i = 0; i < 10; i++) begin
            sp = $random(seed) % 50;
            th = 5 + ($random(seed) & 63);
            hi = 10 + ($random(seed) & 63);
            lo = 10 + ($random(seed) & 63);
            hy = 1 + ($random(seed) & 7);
            wr(TAC_OFS_SETPOINT, 32'(sp));
            wr(TAC_OFS_THRESH1, 32'(th));
            wr(TAC_OFS_HIGH1, 32'(hi));
            wr(TAC_OFS_LOW1, 32'(lo));
            wr(TAC_OFS_DEADBAND1, 32'(hy));
            wr(TAC_OFS_KIND, {28'h0, kt[i]});
            restart();
            p = 1'b0;
            arm = (i > 5);
            repeat (12) begin
                pv = sp + $random(seed) % 150;
                d = !arm && ref_det(kb[i], pv, sp, th, hi, lo, hy, p);
                if (!ref_det(kb[i], pv, sp, th, hi, lo, hy, 1'b0)) arm = 1'b0;
                smp(16'(pv), {1'b0, d}, d && !p);
                p = d;
            end
        end
        complete_run();
    end
endmodule // temperature_alarm_comparator_bench
